// file: design/trs_defines.svh
`ifndef TRS_DEFINES_SVH
`define TRS_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TRS_A_LCH      7'h38
`define TRS_A_PCH      7'h39
`define TRS_A_CSR      7'h3a
`define TRS_A_OFS      7'h3b
`define TRS_A_DAT      7'h3c

// ----------------------------------------
// control and status fields
// ----------------------------------------
`define TRS_CSR_WR     0
`define TRS_CSR_RD     1
`define TRS_CSR_MD_LO  2
`define TRS_CSR_MD_HI  3
`define TRS_CSR_BUSY   8
`define TRS_CSR_ERR    9
`define TRS_MODE_STRM  2'b00
`define TRS_MODE_DIR   2'b01
`define TRS_MODE_RST   2'b00

// ----------------------------------------
// internal streaming registers
// ----------------------------------------
`define TRS_I_BASE     16'h0000
`define TRS_I_CTRL     16'h0001
`define TRS_I_STAT     16'h0002
`define TRS_CTL_START  0
`define TRS_CTL_CLR    2
`define TRS_ST_INV     0
`define TRS_ST_OPC     1
`define TRS_ST_MISM    4

// ----------------------------------------
// record layout and opcodes
// ----------------------------------------
`define TRS_LEN_HI     15
`define TRS_LEN_LO     11
`define TRS_OP_HI      4
`define TRS_OFS_HI     10
`define TRS_KIND_HI    6
`define TRS_KIND_LO    5
`define TRS_OP_RSV0    5'h00
`define TRS_OP_START   5'h01
`define TRS_OP_TYPE    5'h02
`define TRS_OP_CLKSW   5'h03
`define TRS_OP_PLLSW   5'h04
`define TRS_OP_END     5'h1f

`endif

// file: design/trs_pkg.sv
package trs_pkg;
    typedef enum logic [2:0] {S_IDLE, S_CHAN, S_FETCH, S_PARSE, S_WRITE} trs_state_e;
    typedef logic [1:0]  trs_kind_t;
    typedef logic [15:0] trs_rec_t;
endpackage

// file: design/trs_int_if.sv
`timescale 1ns/1ps
interface trs_int_if;
    trs_pkg::trs_rec_t  rec;     // record under decode
    logic               is_data; // nonzero length
    logic [4:0]         len;     // record length field
    logic [4:0]         opcode;  // opcode field
    logic               rsvd;    // reserved opcode
    logic [10:0]        offset;  // logical offset field
    trs_pkg::trs_kind_t kind;    // image channel type
    logic               req;     // channel access request
    logic               we;      // request is a write
    logic [9:0]         ch;      // logical channel
    logic [15:0]        ofs;     // setting offset
    logic [31:0]        wdata;   // setting value
    logic               done;    // access finished
    logic [31:0]        rdata;   // fetched setting
    modport core (output rec, req, we, ch, ofs, wdata,
                  input is_data, len, opcode, rsvd, offset, kind, done, rdata);
    modport dec  (input rec, output is_data, len, opcode, rsvd, offset, kind);
    modport acc  (input req, we, ch, ofs, wdata, output done, rdata);
endinterface // trs_int_if

// file: design/trs_rec_decode.sv
`timescale 1ns/1ps
`include "trs_defines.svh"
module trs_rec_decode (
    trs_int_if.dec ib // record in, fields out
);
    import trs_pkg::*;

    assign ib.len     = ib.rec[`TRS_LEN_HI:`TRS_LEN_LO];
    assign ib.is_data = (ib.len != 5'h00);
    assign ib.opcode  = ib.rec[`TRS_OP_HI:0];
    assign ib.offset  = ib.rec[`TRS_OFS_HI:0];
    assign ib.kind    = ib.rec[`TRS_KIND_HI:`TRS_KIND_LO];
    assign ib.rsvd    = (ib.opcode == `TRS_OP_RSV0) ||
                        ((ib.opcode > `TRS_OP_PLLSW) && (ib.opcode != `TRS_OP_END));
endmodule // trs_rec_decode

// file: design/trs_chan_port.sv
`timescale 1ns/1ps
module trs_chan_port (
    input  wire logic        core_clk,  // system clock
    input  wire logic        reset,     // async reset
    trs_int_if.acc           ib,        // request from core
    output wire logic [9:0]  ch_num,    // logical channel
    output wire logic [15:0] ch_offset, // setting offset
    output wire logic [31:0] ch_wdata,  // setting value
    output wire logic        ch_write,  // write request
    output wire logic        ch_read,   // read request
    input  wire logic [31:0] ch_rdata,  // read value
    input  wire logic        ch_ack     // request accepted
);
    import trs_pkg::*;

    logic [9:0]  num_r;
    logic [15:0] ofs_r;
    logic [31:0] wd_r;
    logic        wr_r;
    logic        rd_r;

    // request held until the channel acknowledges it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            num_r    <= 10'h000;
            ofs_r    <= 16'h0000;
            wd_r     <= 32'h0;
            wr_r     <= 1'b0;
            rd_r     <= 1'b0;
            ib.done  <= 1'b0;
            ib.rdata <= 32'h0;
        end else begin
            ib.done <= 1'b0;
            if (ib.req) begin
                num_r <= ib.ch;
                ofs_r <= ib.ofs;
                wd_r  <= ib.wdata;
                wr_r  <= ib.we;
                rd_r  <= !ib.we;
            end else if ((wr_r || rd_r) && ch_ack) begin
                wr_r     <= 1'b0;
                rd_r     <= 1'b0;
                ib.done  <= 1'b1;
                ib.rdata <= ch_rdata;
            end
        end
    end

    assign ch_num    = num_r;
    assign ch_offset = ofs_r;
    assign ch_wdata  = wd_r;
    assign ch_write  = wr_r;
    assign ch_read   = rd_r;

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    a_req_held: assert property ((wr_r && !ch_ack) |=> wr_r && $stable(ofs_r))
        else $error("channel write dropped before acknowledge");
endmodule // trs_chan_port

// file: design/trs_streamer.sv
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "trs_defines.svh"
module trs_streamer (
    input  wire logic               core_clk,      // system clock
    input  wire logic               reset,         // async reset
    input  wire logic [6:0]         reg_addr,      // register address
    input  wire logic [31:0]        reg_wdata,     // register write data
    input  wire logic               reg_write,     // write strobe
    input  wire logic               reg_read,      // read strobe
    output wire logic [31:0]        reg_rdata,     // read data, next cycle
    output wire logic [31:0]        mem_addr,      // image word address
    output wire logic               mem_read,      // image fetch request
    input  wire logic [15:0]        mem_rdata,     // image record
    input  wire logic               mem_valid,     // record valid
    output wire logic [9:0]         ch_num,        // logical channel
    output wire logic [15:0]        ch_offset,     // setting offset
    output wire logic [31:0]        ch_wdata,      // setting value
    output wire logic               ch_write,      // setting write request
    output wire logic               ch_read,       // setting read request
    input  wire logic [31:0]        ch_rdata,      // setting read value
    input  wire logic               ch_ack,        // channel acknowledge
    input  wire trs_pkg::trs_kind_t chan_kind,     // type of logical channel
    output wire trs_pkg::trs_kind_t image_kind,    // type from image
    output wire logic               refclk_switch, // clock-recovery input switch
    output wire logic               pll_switch     // PLL switch
);
    import trs_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    trs_int_if ib ();

    logic [9:0]  lch_r;
    logic [1:0]  mode_r;
    logic [15:0] ofs_r;
    logic [31:0] data_r;
    logic [31:0] base_r;
    logic [31:0] mptr_r;
    logic [31:0] rdata_r;
    logic        err_opc_r;
    logic        err_mism_r;
    logic        err_inv_r;
    trs_state_e  st_r;
    logic [4:0]  left_r;
    logic [10:0] woff_r;
    logic        first_r;
    trs_rec_t    rec_r;
    logic        mem_read_r;
    logic        req_r;
    logic        we_r;
    logic [15:0] cofs_r;
    logic [31:0] cdat_r;
    trs_kind_t   kind_r;
    logic        clk_sw_r;
    logic        pll_sw_r;

    logic        busy;
    logic        any_err;
    logic [1:0]  wmode;
    logic        wr_csr;
    logic        trig_w;
    logic        trig_r;
    logic        in_strm;
    logic        in_dir;
    logic        ctl_wr;
    logic        clr_err;
    logic        start_ok;
    logic        parse_hdr;
    logic        bad_first;
    logic        bad_op;
    logic        bad_kind;
    logic        bad_acc;
    logic [31:0] stat_v;
    logic [31:0] csr_v;
    logic [31:0] irdata;

    // ----------------------------------------
    // submodules
    // ----------------------------------------
    trs_rec_decode u_dec (
        .ib (ib.dec)
    );

    trs_chan_port u_port (
        .core_clk  (core_clk),
        .reset     (reset),
        .ib        (ib.acc),
        .ch_num    (ch_num),
        .ch_offset (ch_offset),
        .ch_wdata  (ch_wdata),
        .ch_write  (ch_write),
        .ch_read   (ch_read),
        .ch_rdata  (ch_rdata),
        .ch_ack    (ch_ack)
    );

    assign ib.rec   = rec_r;
    assign ib.req   = req_r;
    assign ib.we    = we_r;
    assign ib.ch    = lch_r;
    assign ib.ofs   = cofs_r;
    assign ib.wdata = cdat_r;

    // ----------------------------------------
    // trigger decode
    // ----------------------------------------
    assign busy      = (st_r != S_IDLE);
    assign any_err   = err_opc_r | err_mism_r | err_inv_r;
    assign wmode     = reg_wdata[`TRS_CSR_MD_HI:`TRS_CSR_MD_LO];
    assign wr_csr    = reg_write && (reg_addr == `TRS_A_CSR);
    assign trig_w    = wr_csr && reg_wdata[`TRS_CSR_WR] && !busy;
    assign trig_r    = wr_csr && reg_wdata[`TRS_CSR_RD] && !reg_wdata[`TRS_CSR_WR] && !busy;
    assign in_strm   = (wmode == `TRS_MODE_STRM);
    assign in_dir    = (wmode == `TRS_MODE_DIR);
    assign ctl_wr    = trig_w && in_strm && (ofs_r == `TRS_I_CTRL);
    assign clr_err   = ctl_wr && data_r[`TRS_CTL_CLR];
    assign start_ok  = ctl_wr && data_r[`TRS_CTL_START] && (!any_err || clr_err);
    assign bad_acc   = (trig_w || trig_r) &&
                       ((!in_strm && !in_dir) || (in_strm && (ofs_r > `TRS_I_STAT)));

    // ----------------------------------------
    // record checks
    // ----------------------------------------
    assign parse_hdr = (st_r == S_PARSE) && (left_r == 5'h00);
    assign bad_first = parse_hdr && first_r &&
                       (ib.is_data || (ib.opcode != `TRS_OP_START));
    assign bad_op    = parse_hdr && !first_r && !ib.is_data && ib.rsvd;
    assign bad_kind  = parse_hdr && !first_r && !ib.is_data &&
                       (ib.opcode == `TRS_OP_TYPE) && (ib.kind != chan_kind);

    // ----------------------------------------
    // host registers
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lch_r  <= 10'h000;
            mode_r <= `TRS_MODE_RST;
            ofs_r  <= 16'h0000;
        end else if (reg_write) begin
            if (reg_addr == `TRS_A_LCH) begin
                lch_r <= reg_wdata[9:0];
            end else if (reg_addr == `TRS_A_CSR) begin
                mode_r <= wmode;
            end else if (reg_addr == `TRS_A_OFS) begin
                ofs_r <= reg_wdata[15:0];
            end
        end
    end

    always_comb begin
        irdata = 32'h0;
        if (ofs_r == `TRS_I_BASE) begin
            irdata = base_r;
        end else if (ofs_r == `TRS_I_STAT) begin
            irdata = stat_v;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            data_r <= 32'h0;
        end else if ((st_r == S_CHAN) && ib.done && !we_r) begin
            data_r <= ib.rdata;
        end else if (trig_r && in_strm && !bad_acc) begin
            data_r <= irdata;
        end else if (reg_write && (reg_addr == `TRS_A_DAT)) begin
            data_r <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            base_r <= 32'h0;
        end else if (trig_w && in_strm && (ofs_r == `TRS_I_BASE)) begin
            base_r <= data_r;
        end
    end

    // new errors win over a clear in the same cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            err_opc_r  <= 1'b0;
            err_mism_r <= 1'b0;
            err_inv_r  <= 1'b0;
        end else begin
            err_opc_r  <= (err_opc_r & ~clr_err) | bad_first | bad_op;
            err_mism_r <= (err_mism_r & ~clr_err) | bad_kind;
            err_inv_r  <= (err_inv_r & ~clr_err) | bad_acc;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_r       <= S_IDLE;
            left_r     <= 5'h00;
            woff_r     <= 11'h000;
            first_r    <= 1'b0;
            rec_r      <= 16'h0000;
            mptr_r     <= 32'h0;
            mem_read_r <= 1'b0;
            req_r      <= 1'b0;
            we_r       <= 1'b0;
            cofs_r     <= 16'h0000;
            cdat_r     <= 32'h0;
            kind_r     <= 2'b00;
            clk_sw_r   <= 1'b0;
            pll_sw_r   <= 1'b0;
        end else begin
            req_r    <= 1'b0;
            clk_sw_r <= 1'b0;
            pll_sw_r <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    if (trig_w && in_dir) begin
                        req_r  <= 1'b1;
                        we_r   <= 1'b1;
                        cofs_r <= ofs_r;
                        cdat_r <= data_r;
                        st_r   <= S_CHAN;
                    end else if (trig_r && in_dir) begin
                        req_r  <= 1'b1;
                        we_r   <= 1'b0;
                        cofs_r <= ofs_r;
                        st_r   <= S_CHAN;
                    end else if (start_ok) begin
                        mptr_r     <= base_r;
                        first_r    <= 1'b1;
                        left_r     <= 5'h00;
                        mem_read_r <= 1'b1;
                        st_r       <= S_FETCH;
                    end
                end
                S_CHAN: begin
                    if (ib.done) begin
                        st_r <= S_IDLE;
                    end
                end
                S_FETCH: begin
                    if (mem_valid) begin
                        rec_r      <= mem_rdata;
                        mem_read_r <= 1'b0;
                        mptr_r     <= mptr_r + 32'h1;
                        st_r       <= S_PARSE;
                    end
                end
                S_PARSE: begin
                    first_r <= 1'b0;
                    if (left_r != 5'h00) begin
                        req_r  <= 1'b1;
                        we_r   <= 1'b1;
                        cofs_r <= {5'h00, woff_r};
                        cdat_r <= {16'h0000, rec_r};
                        left_r <= left_r - 5'h01;
                        woff_r <= woff_r + 11'h001;
                        st_r   <= S_WRITE;
                    end else if (bad_first || bad_op || bad_kind) begin
                        st_r <= S_IDLE;
                    end else if (ib.is_data) begin
                        left_r     <= ib.len;
                        woff_r     <= ib.offset;
                        mem_read_r <= 1'b1;
                        st_r       <= S_FETCH;
                    end else if (ib.opcode == `TRS_OP_END) begin
                        st_r <= S_IDLE;
                    end else begin
                        if (ib.opcode == `TRS_OP_TYPE) begin
                            kind_r <= ib.kind;
                        end
                        clk_sw_r   <= (ib.opcode == `TRS_OP_CLKSW);
                        pll_sw_r   <= (ib.opcode == `TRS_OP_PLLSW);
                        mem_read_r <= 1'b1;
                        st_r       <= S_FETCH;
                    end
                end
                S_WRITE: begin
                    if (ib.done) begin
                        mem_read_r <= 1'b1;
                        st_r       <= S_FETCH;
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // read back
    // ----------------------------------------
    always_comb begin
        stat_v                 = 32'h0;
        stat_v[`TRS_ST_INV]    = err_inv_r;
        stat_v[`TRS_ST_OPC]    = err_opc_r;
        stat_v[`TRS_ST_MISM]   = err_mism_r;
        csr_v                  = 32'h0;
        csr_v[`TRS_CSR_ERR]    = any_err;
        csr_v[`TRS_CSR_BUSY]   = busy;
        csr_v[`TRS_CSR_MD_HI:`TRS_CSR_MD_LO] = mode_r;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= 32'h0;
            if (reg_read) begin
                if ((reg_addr == `TRS_A_LCH) || (reg_addr == `TRS_A_PCH)) begin
                    rdata_r <= {22'h0, lch_r};
                end else if (reg_addr == `TRS_A_CSR) begin
                    rdata_r <= csr_v;
                end else if (reg_addr == `TRS_A_OFS) begin
                    rdata_r <= {16'h0000, ofs_r};
                end else if (reg_addr == `TRS_A_DAT) begin
                    rdata_r <= data_r;
                end
            end
        end
    end

    assign reg_rdata     = rdata_r;
    assign mem_addr      = mptr_r;
    assign mem_read      = mem_read_r;
    assign image_kind    = kind_r;
    assign refclk_switch = clk_sw_r;
    assign pll_switch    = pll_sw_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    a_busy_write_hold: assert property ((st_r == S_CHAN && !ib.done) |=> busy)
        else $error("busy dropped before channel access finished");
    a_read_data_kept: assert property ((st_r == S_CHAN && ib.done && !we_r) |=> data_r == $past(ib.rdata))
        else $error("read result not left in data register");
    a_trig_dropped: assert property ((st_r == S_CHAN && wr_csr) |=> !req_r)
        else $error("trigger accepted while busy");
    a_end_stops: assert property ((parse_hdr && !first_r && !ib.is_data && ib.opcode == `TRS_OP_END)
        |=> st_r == S_IDLE && !mem_read_r ##1 !mem_read_r)
        else $error("fetch continued after end opcode");
    a_first_start: assert property ((parse_hdr && first_r && ib.is_data) |=> err_opc_r && !busy)
        else $error("missing start opcode not flagged");
    a_type_match: assert property (bad_kind |=> err_mism_r && st_r == S_IDLE)
        else $error("image type mismatch not flagged");
    a_start_refused: assert property ((st_r == S_IDLE && any_err && ctl_wr && !clr_err) |=> st_r == S_IDLE)
        else $error("streaming started with error recorded");
    a_data_word: assert property ((st_r == S_PARSE && left_r != 5'h00)
        |=> req_r && we_r && cdat_r[15:0] == $past(rec_r))
        else $error("data word not written to channel");
    a_header_load: assert property ((parse_hdr && !first_r && ib.is_data)
        |=> left_r == $past(rec_r[15:11]) && woff_r == $past(rec_r[10:0]))
        else $error("data header fields not taken");
    a_self_clear: assert property ((reg_read && reg_addr == `TRS_A_CSR) |=> reg_rdata[1:0] == 2'b00)
        else $error("trigger bits did not read back clear");
    a_fetch_hold: assert property ((mem_read_r && !mem_valid) |=> mem_read_r && $stable(mem_addr))
        else $error("image fetch dropped before valid");
endmodule // trs_streamer

// file: sim/trs_far_model.sv
`timescale 1ns/1ps
module trs_far_model (
    input  wire logic        core_clk,  // system clock
    input  wire logic        reset,     // async reset
    input  wire logic [31:0] mem_addr,  // record address
    input  wire logic        mem_read,  // fetch request
    output logic      [15:0] mem_rdata, // record
    output logic             mem_valid, // record valid
    input  wire logic [15:0] ch_offset, // setting offset
    input  wire logic        ch_req,    // write or read request
    output logic      [31:0] ch_rdata,  // setting value
    output logic             ch_ack     // acknowledge
);
    logic [15:0] img [0:127];
    logic [1:0]  wait_r;
    // odd addresses answer slowly; idle lines toggle rather than hold
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wait_r <= 2'h0;
            mem_valid <= 1'b0;
            mem_rdata <= 16'h0;
        end else begin
            wait_r <= (mem_read && !mem_valid) ? wait_r + 2'h1 : 2'h0;
            mem_valid <= mem_read && !mem_valid && wait_r >= {mem_addr[0], 1'b0};
            mem_rdata <= (mem_read && !mem_valid) ? img[mem_addr[6:0]] : ~mem_rdata;
        end
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ch_ack <= 1'b0;
            ch_rdata <= 32'h0;
        end else begin
            ch_ack <= ch_req && !ch_ack;
            ch_rdata <= (ch_req && !ch_ack) ? {16'hc0de, ch_offset} : ~ch_rdata;
        end
    end
endmodule // trs_far_model

// file: sim/tb_top.sv
`timescale 1ns/1ps
`include "trs_defines.svh"
module tb_top;
    logic core_clk = 0, reset = 1, reg_write = 0, reg_read = 0, mem_read, mem_valid;
    logic [6:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, mem_addr, ch_wdata, ch_rdata, v, last_addr;
    logic [15:0] mem_rdata, ch_offset;
    logic [9:0] ch_num;
    logic ch_write, ch_read, ch_ack, refclk_switch, pll_switch, busy_seen;
    logic [1:0] chan_kind = 2'b01, image_kind;
    logic [47:0] wq[$];
    logic [15:0] codes [0:3] = '{16'h0, 16'h0, 16'h5, 16'h1e};
    int n_mismatch = 0, n_compared = 0, n_clk = 0, n_pll = 0;
    always #20 core_clk = ~core_clk;
    trs_streamer DUT (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .mem_addr, .mem_read, .mem_rdata, .mem_valid, .ch_num, .ch_offset, .ch_wdata, .ch_write,
        .ch_read, .ch_rdata, .ch_ack, .chan_kind, .image_kind, .refclk_switch, .pll_switch);
    trs_far_model FAR (.core_clk, .reset, .mem_addr, .mem_read, .mem_rdata, .mem_valid,
        .ch_offset, .ch_req(ch_write | ch_read), .ch_rdata, .ch_ack);
    always @(posedge core_clk) begin
        if (ch_write && ch_ack) wq.push_back({ch_offset, ch_wdata});
        if (mem_read && mem_valid) last_addr <= mem_addr;
        n_clk += refclk_switch;
        n_pll += pll_switch;
    end
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic poll;
        logic [31:0] s;
        for (int i = 0; i < 300; i++) begin
            rd(`TRS_A_CSR, s);
            if (s[8] === 1'b0) return;
        end
        n_mismatch++;
        report_and_stop;
    endtask
    task automatic stream(input logic [31:0] base, input logic [31:0] ctl);
        wr(`TRS_A_OFS, 0);
        wr(`TRS_A_DAT, base);
        wr(`TRS_A_CSR, 1);
        wr(`TRS_A_OFS, 1);
        wr(`TRS_A_DAT, ctl);
        wr(`TRS_A_CSR, 1);
        rd(`TRS_A_CSR, v);
        busy_seen = v[8];
        poll;
    endtask
    task automatic status(output logic [31:0] s);
        wr(`TRS_A_OFS, 2);
        wr(`TRS_A_CSR, 2);
        rd(`TRS_A_DAT, s);
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        foreach (FAR.img[i]) FAR.img[i] = 16'h1005;
        FAR.img[64:74] = '{16'h0001, 16'h0022, 16'h0003, 16'h0004, 16'h1005, 16'habcd, 16'h1234,
            16'h0814, 16'h5a5a, 16'h001f, 16'h1005};
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        rd(`TRS_A_CSR, v);
        chk(v, 0);
        wr(`TRS_A_LCH, 3);
        wr(`TRS_A_OFS, 'h15);
        wr(`TRS_A_DAT, 'h28);
        wr(`TRS_A_CSR, 5);
        wr(`TRS_A_CSR, 5);
        rd(`TRS_A_CSR, v);
        chk(v[8], 1);
        poll;
        chk(wq.size(), 1);
        chk(wq[0], {16'h15, 32'h28});
        chk(ch_num, 3);
        wr(`TRS_A_OFS, 7);
        wr(`TRS_A_CSR, 6);
        poll;
        rd(`TRS_A_DAT, v);
        chk(v, 32'hc0de0007);
        $display("direct access test done");
        wq.delete();
        stream('h40, 1);
        chk(busy_seen, 1);
        chk(wq.size(), 3);
        chk(wq[0], {16'h5, 32'habcd});
        chk(wq[1], {16'h6, 32'h1234});
        chk(wq[2], {16'h14, 32'h5a5a});
        chk({n_clk, n_pll}, {32'd1, 32'd1});
        chk(image_kind, 2'b01);
        chk(last_addr, 'h49);
        $display("stream test done");
        for (int i = 0; i < 4; i++) begin
            FAR.img[96:98] = '{(i == 0) ? 16'h1005 : 16'h0001, codes[i], 16'h001f};
            stream('h60, 5);
            status(v);
            chk(v, 2);
        end
        rd(`TRS_A_CSR, v);
        chk(v, 32'h200);
        stream('h40, 1);
        chk(wq.size(), 3);
        @(posedge core_clk);
        chan_kind <= 2'b10;
        stream('h40, 5);
        status(v);
        chk(v, 32'h10);
        $display("error test done");
        report_and_stop;
    end
endmodule // tb_top
